// ---- verilog/frig_map.svh ----
// register offsets, field codes, result values and timing figures
`ifndef FRIG_MAP_SVH
`define FRIG_MAP_SVH

`define FRIG_CLK_MHZ 250
`define FRIG_CONV11_TIME_US 510
`define FRIG_CONV14_TIME_US 940

`define FRIG_OFS_SENSE_HI 8'h12
`define FRIG_OFS_SENSE_LO 8'h13
`define FRIG_OFS_OVF_STATUS 8'h1c
`define FRIG_OFS_POWER_HI 8'h1d
`define FRIG_OFS_POWER_LO 8'h1e

`define FRIG_OVF_SENSE_BIT 2
`define FRIG_OVF_POWER_BIT 0

`define FRIG_SAT_RESULT 16'hffc0
`define FRIG_MAX_SAMPLES 12'h800
`define FRIG_MAX_SHIFT 4'hb

`define FRIG_SEL_PIN 2'h0
`define FRIG_SEL_SENSE 2'h1
`define FRIG_SEL_BUS 2'h2
`define FRIG_SEL_POWER 2'h3

`endif

// ---- verilog/frig_pkg.sv ----
// types shared by the free-run integration sequencer
package frig_pkg;
	typedef enum logic [1:0] {
		FRIG_IDLE,
		FRIG_BUS,
		FRIG_SENSE,
		FRIG_CALC
	} frig_state_t;
	typedef logic [1:0] frig_osel_t;
	typedef logic [2:0] frig_gain_t;
endpackage

// ---- verilog/frig_conv_timer.sv ----
// conversion timer: one conversion's length from resolution and filter
module frig_conv_timer #(
	parameter int CW = 20,
	parameter int BASE11_CYC = 1000,
	parameter int BASE14_CYC = 2000
) (
	input wire logic sys_clk_in, // system clock
	input wire logic rst_in, // sync reset, active high
	input wire logic start_in, // start one conversion
	input wire logic abort_in, // drop a running conversion
	input wire logic res14_in, // 14-bit resolution
	input wire logic filt_in, // post filter on
	output logic done_out // one-cycle end of conversion
);
	logic [CW-1:0] cnt_q, cnt_d, base_len, conv_len;
	logic busy_q, busy_d, done_q, done_d;

	always_comb begin
		base_len = res14_in ? CW'(BASE14_CYC) : CW'(BASE11_CYC);
		// filtering lengthens the conversion by half
		conv_len = filt_in ? base_len + (base_len >> 1) : base_len;
		cnt_d = cnt_q;
		busy_d = busy_q;
		done_d = 1'b0;
		if (abort_in) begin
			busy_d = 1'b0;
		end else if (start_in) begin
			cnt_d = conv_len;
			busy_d = 1'b1;
		end else if (busy_q) begin
			cnt_d = cnt_q - CW'(1);
			if (cnt_q == CW'(1)) begin
				busy_d = 1'b0;
				done_d = 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			cnt_q <= '0;
			busy_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			busy_q <= busy_d;
			done_q <= done_d;
		end
	end

	assign done_out = done_q;

	a_filter_length: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		start_in && !abort_in && filt_in |=> cnt_q == $past(base_len) + ($past(base_len) >> 1))
		else $error("filtered conversion length is not one and a half");
endmodule // frig_conv_timer

// ---- verilog/frig_top.sv ----
// free-run integration sequencer with current gain and overflow handling
//
// Function
// - sample count is two to code, cap 2048
// - 11 or 14 bits per channel
// - filter lengthens conversion by half
// - power sample: bus then sense conversion
// - single channel mode converts only that channel
// - period end latches result into DAC
// - integrate state restarts period after calculation
// - read state stops, discards partial period
// - period length follows type, count, resolution, filter
// - current gain is two to code
// - detect gain overflow in sense or power
// - overflow sets status bit 2, bit 0
// - sense overflow saturates sense result ffc0
// - power overflow saturates power result ffc0
// - accumulators stay exact, only results clamp
// - DAC takes upper ten result bits
// - stop at 2048 samples then compute
// - output select picks type and mode
`include "frig_map.svh"

module frig_top #(
	parameter int CONV11_CYC = `FRIG_CONV11_TIME_US * `FRIG_CLK_MHZ,
	parameter int CONV14_CYC = (`FRIG_CONV14_TIME_US * `FRIG_CLK_MHZ) / 1
) (
	input wire logic sys_clk_in, // 250 MHz clock
	input wire logic rst_in, // sync reset, active high
	input wire logic integrate_in, // high: integrate state, low: read
	input wire frig_pkg::frig_osel_t output_select_field_in, // type, mode
	input wire logic [3:0] sample_count_code_in, // samples per period
	input wire logic sense_resolution_sel_in, // sense: 1 = 14 bit
	input wire logic bus_resolution_sel_in, // bus: 1 = 14 bit
	input wire logic sense_filter_en_in, // sense post filter
	input wire logic bus_filter_en_in, // bus post filter
	input wire frig_pkg::frig_gain_t current_gain_code_in, // gain code
	input wire logic recalc_output_bit_in, // pulse: recalc in read
	input wire logic [13:0] adc_sense_in, // sense sample, right aligned
	input wire logic [13:0] adc_bus_in, // bus sample, right aligned
	input wire logic [7:0] reg_addr_in, // register read address
	output logic [7:0] reg_rdata_out, // register data, one cycle later
	output logic [9:0] dac_out, // output DAC code
	output logic integrating_out // a period is running
);
	import frig_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	frig_state_t state_q, state_d;
	frig_osel_t osel_q, osel_d;
	logic [3:0] shift_q, shift_d;
	logic [11:0] target_q, target_d;
	logic [11:0] cnt_q, cnt_d;
	logic sres_q, sres_d, bres_q, bres_d, sfil_q, sfil_d, bfil_q, bfil_d;
	logic [24:0] isum_q, isum_d, bsum_q, bsum_d, last_isum_q, last_isum_d;
	logic [24:0] last_bsum_q, last_bsum_d;
	logic [38:0] psum_q, psum_d, last_psum_q, last_psum_d;
	logic [13:0] bus_smp_q, bus_smp_d, s_norm, b_norm;
	logic [27:0] prod;
	logic start_q, start_d, recalc_q, recalc_d, smp_done, conv_done;
	logic integ_q, integ_d;
	logic [3:0] code_shift;

	always_comb begin
		s_norm = sres_q ? adc_sense_in : {adc_sense_in[10:0], 3'h0};
		b_norm = bres_q ? adc_bus_in : {adc_bus_in[10:0], 3'h0};
		prod = bus_smp_q * s_norm;
		// codes above 11 all mean 2048 samples
		code_shift = (sample_count_code_in > `FRIG_MAX_SHIFT) ?
			`FRIG_MAX_SHIFT : sample_count_code_in;
	end

	always_comb begin
		state_d = state_q;
		osel_d = osel_q;
		shift_d = shift_q;
		target_d = target_q;
		sres_d = sres_q;
		bres_d = bres_q;
		sfil_d = sfil_q;
		bfil_d = bfil_q;
		cnt_d = cnt_q;
		isum_d = isum_q;
		bsum_d = bsum_q;
		psum_d = psum_q;
		last_isum_d = last_isum_q;
		last_bsum_d = last_bsum_q;
		last_psum_d = last_psum_q;
		bus_smp_d = bus_smp_q;
		start_d = 1'b0;
		recalc_d = recalc_q;
		smp_done = 1'b0;
		case (state_q)
			FRIG_IDLE: begin
				// count, resolution and filter settings only take hold when integration starts from idle
				if (integrate_in && output_select_field_in != `FRIG_SEL_PIN) begin
					osel_d = output_select_field_in;
					shift_d = code_shift;
					target_d = 12'h1 << code_shift;
					sres_d = sense_resolution_sel_in;
					bres_d = bus_resolution_sel_in;
					sfil_d = sense_filter_en_in;
					bfil_d = bus_filter_en_in;
					cnt_d = '0;
					isum_d = '0;
					bsum_d = '0;
					psum_d = '0;
					recalc_d = 1'b0;
					start_d = 1'b1;
					state_d = (output_select_field_in == `FRIG_SEL_SENSE) ?
						FRIG_SENSE : FRIG_BUS;
				end else if (recalc_output_bit_in) begin
					recalc_d = 1'b1;
					state_d = FRIG_CALC;
				end
			end
			FRIG_BUS, FRIG_SENSE: begin
				if (!integrate_in) begin
					// read state: the partial period is thrown away
					cnt_d = '0;
					isum_d = '0;
					bsum_d = '0;
					psum_d = '0;
					state_d = FRIG_IDLE;
				end else if (conv_done && state_q == FRIG_BUS) begin
					bus_smp_d = b_norm;
					bsum_d = bsum_q + 25'(b_norm);
					if (osel_q == `FRIG_SEL_POWER) begin
						start_d = 1'b1;
						state_d = FRIG_SENSE;
					end else begin
						smp_done = 1'b1;
					end
				end else if (conv_done) begin
					isum_d = isum_q + 25'(s_norm);
					psum_d = psum_q + 39'(prod);
					smp_done = 1'b1;
				end
			end
			FRIG_CALC: begin
				recalc_d = 1'b0;
				if (integrate_in && output_select_field_in != `FRIG_SEL_PIN &&
					!recalc_q) begin
					// a new mode is picked up between periods
					osel_d = output_select_field_in;
					cnt_d = '0;
					isum_d = '0;
					bsum_d = '0;
					psum_d = '0;
					start_d = 1'b1;
					state_d = (output_select_field_in == `FRIG_SEL_SENSE) ?
						FRIG_SENSE : FRIG_BUS;
				end else begin
					state_d = FRIG_IDLE;
				end
			end
			default: state_d = FRIG_IDLE;
		endcase
		if (smp_done) begin
			cnt_d = cnt_q + 12'h1;
			if (cnt_d == target_q) begin
				// accumulators copied whole, never clamped
				last_isum_d = isum_d;
				last_bsum_d = bsum_d;
				last_psum_d = psum_d;
				state_d = FRIG_CALC;
			end else begin
				start_d = 1'b1;
				state_d = (osel_q == `FRIG_SEL_SENSE) ? FRIG_SENSE : FRIG_BUS;
			end
		end
		integ_d = state_d == FRIG_BUS || state_d == FRIG_SENSE;
	end

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			state_q <= FRIG_IDLE;
			osel_q <= `FRIG_SEL_PIN;
			shift_q <= '0;
			target_q <= 12'h1;
			sres_q <= 1'b0;
			bres_q <= 1'b0;
			sfil_q <= 1'b0;
			bfil_q <= 1'b0;
			cnt_q <= '0;
			isum_q <= '0;
			bsum_q <= '0;
			psum_q <= '0;
			last_isum_q <= '0;
			last_bsum_q <= '0;
			last_psum_q <= '0;
			bus_smp_q <= '0;
			start_q <= 1'b0;
			recalc_q <= 1'b0;
			integ_q <= 1'b0;
		end else begin
			state_q <= state_d;
			osel_q <= osel_d;
			shift_q <= shift_d;
			target_q <= target_d;
			sres_q <= sres_d;
			bres_q <= bres_d;
			sfil_q <= sfil_d;
			bfil_q <= bfil_d;
			cnt_q <= cnt_d;
			isum_q <= isum_d;
			bsum_q <= bsum_d;
			psum_q <= psum_d;
			last_isum_q <= last_isum_d;
			last_bsum_q <= last_bsum_d;
			last_psum_q <= last_psum_d;
			bus_smp_q <= bus_smp_d;
			start_q <= start_d;
			recalc_q <= recalc_d;
			integ_q <= integ_d;
		end
	end

	// ----------------------------------------------------------------
	// conversion timing
	// ----------------------------------------------------------------
	frig_conv_timer #(
		.CW(20),
		.BASE11_CYC(CONV11_CYC),
		.BASE14_CYC(CONV14_CYC)
	) frig_conv_timer_i (
		.sys_clk_in(sys_clk_in),
		.rst_in(rst_in),
		.start_in(start_q),
		.abort_in(state_q == FRIG_IDLE || state_q == FRIG_CALC),
		.res14_in(state_q == FRIG_SENSE ? sres_q : bres_q),
		.filt_in(state_q == FRIG_SENSE ? sfil_q : bfil_q),
		.done_out(conv_done)
	);

	// ----------------------------------------------------------------
	// result calculation and registers
	// ----------------------------------------------------------------
	logic [15:0] sense_res_q, sense_res_d, power_res_q, power_res_d;
	logic [15:0] bus_res_q, bus_res_d, s16, p16;
	logic [22:0] s_gain, p_gain;
	logic [24:0] average_current, b_avg;
	logic [38:0] p_avg;
	logic s_ovf, p_ovf, sov_q, sov_d, pov_q, pov_d;
	logic [9:0] dac_q, dac_d;
	logic [7:0] rdata_q, rdata_d;

	always_comb begin
		average_current = last_isum_q >> shift_q;
		b_avg = last_bsum_q >> shift_q;
		p_avg = last_psum_q >> shift_q;
		s16 = {average_current[13:0], 2'h0};
		p16 = p_avg[27:12];
		s_gain = {7'h0, s16} << current_gain_code_in;
		p_gain = {7'h0, p16} << current_gain_code_in;
		s_ovf = (|s_gain[22:16]) && (osel_q == `FRIG_SEL_SENSE ||
			osel_q == `FRIG_SEL_POWER);
		p_ovf = (|p_gain[22:16]) && osel_q == `FRIG_SEL_POWER;
		sense_res_d = sense_res_q;
		power_res_d = power_res_q;
		bus_res_d = bus_res_q;
		sov_d = sov_q;
		pov_d = pov_q;
		dac_d = dac_q;
		if (state_q == FRIG_CALC) begin
			sov_d = s_ovf;
			pov_d = p_ovf;
			sense_res_d = s_ovf ? `FRIG_SAT_RESULT :
				{s_gain[15:6], 6'h0};
			power_res_d = p_ovf ? `FRIG_SAT_RESULT :
				{p_gain[15:6], 6'h0};
			bus_res_d = {b_avg[13:0], 2'h0};
			case (osel_q)
				`FRIG_SEL_SENSE: dac_d = sense_res_d[15:6];
				`FRIG_SEL_BUS: dac_d = bus_res_d[15:6];
				default: dac_d = power_res_d[15:6];
			endcase
		end
		case (reg_addr_in)
			`FRIG_OFS_SENSE_HI: rdata_d = sense_res_q[15:8];
			`FRIG_OFS_SENSE_LO: rdata_d = sense_res_q[7:0];
			`FRIG_OFS_POWER_HI: rdata_d = power_res_q[15:8];
			`FRIG_OFS_POWER_LO: rdata_d = power_res_q[7:0];
			`FRIG_OFS_OVF_STATUS: begin
				rdata_d = 8'h0;
				rdata_d[`FRIG_OVF_SENSE_BIT] = sov_q;
				rdata_d[`FRIG_OVF_POWER_BIT] = pov_q;
			end
			default: rdata_d = 8'h0;
		endcase
	end

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			sense_res_q <= '0;
			power_res_q <= '0;
			bus_res_q <= '0;
			sov_q <= 1'b0;
			pov_q <= 1'b0;
			dac_q <= '0;
			rdata_q <= '0;
		end else begin
			sense_res_q <= sense_res_d;
			power_res_q <= power_res_d;
			bus_res_q <= bus_res_d;
			sov_q <= sov_d;
			pov_q <= pov_d;
			dac_q <= dac_d;
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata_out = rdata_q;
	assign dac_out = dac_q;
	assign integrating_out = integ_q;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);

	sequence s_bus_done_power;
		state_q == FRIG_BUS && conv_done && integrate_in &&
			osel_q == `FRIG_SEL_POWER;
	endsequence

	sequence s_calc_restart;
		state_q == FRIG_CALC && !recalc_q && integrate_in &&
			output_select_field_in != `FRIG_SEL_PIN;
	endsequence

	a_period_count: assert property (
		state_q == FRIG_CALC && !recalc_q |-> cnt_q == target_q)
		else $error("period completed off its sample count");
	a_power_order: assert property (
		s_bus_done_power |=> state_q == FRIG_SENSE ##1 start_q == 1'b0)
		else $error("power sample did not follow bus with sense");
	a_single_chan: assert property (
		osel_q == `FRIG_SEL_SENSE |-> state_q != FRIG_BUS)
		else $error("sense mode converted the bus channel");
	a_dac_latch: assert property (
		state_q == FRIG_CALC |=> dac_out == $past(dac_d))
		else $error("dac not refreshed at period end");
	a_restart_next: assert property (
		s_calc_restart |=> integrating_out && cnt_q == 12'h0)
		else $error("next period did not start after calculation");
	a_read_discard: assert property (
		integrating_out && !integrate_in |=> state_q == FRIG_IDLE &&
			isum_q == '0 && psum_q == '0 && $stable(dac_out))
		else $error("partial period not discarded on read");
	a_sense_sat: assert property (
		state_q == FRIG_CALC && s_ovf |=> sense_res_q == `FRIG_SAT_RESULT &&
			sov_q)
		else $error("sense overflow did not saturate");
	a_power_sat: assert property (
		state_q == FRIG_CALC && p_ovf |=> power_res_q == 16'hffc0 && pov_q)
		else $error("power overflow did not saturate");
	a_count_cap: assert property (
		cnt_q <= 12'h800 && target_q <= 12'h800)
		else $error("sample count passed 2048");
endmodule // frig_top

// ---- tb/frig_adc_model.sv ----
// front end model: presents one converter sample per channel
module frig_adc_model (
	input wire logic sys_clk_in, // system clock
	input wire logic [13:0] sense_level_in, // wanted sense sample
	input wire logic [13:0] bus_level_in, // wanted bus sample
	output logic [13:0] adc_sense_out, // sense sample to the block
	output logic [13:0] adc_bus_out // bus sample to the block
);
	timeunit 1ns;
	timeprecision 100ps;
	// registered so a level change never lands inside a sampling edge
	always_ff @(posedge sys_clk_in) begin
		adc_sense_out <= sense_level_in;
		adc_bus_out <= bus_level_in;
	end
endmodule // frig_adc_model

// ---- tb/frig_top_tb.sv ----
// self-checking bench for the free-run integration sequencer
module frig_top_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import frig_pkg::*;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic integ = 1'b0;
	frig_osel_t osel = 2'h0;
	logic [3:0] sample_count_code = 4'h0;
	logic res = 1'b0;
	logic filt = 1'b0;
	frig_gain_t gain = 3'h0;
	logic recalc = 1'b0;
	logic [13:0] sense_val = 14'h0000;
	logic [13:0] bus_val = 14'h0000;
	logic [7:0] addr = 8'h00;
	logic [13:0] adc_sense;
	logic [13:0] adc_bus;
	logic [7:0] rdata;
	logic [9:0] dac;
	logic integrating;
	int errors = 0;
	int comparisons = 0;

	always #2 sys_clk = ~sys_clk;

	frig_adc_model frig_adc_model_i (.sys_clk_in(sys_clk),
		.sense_level_in(sense_val), .bus_level_in(bus_val),
		.adc_sense_out(adc_sense), .adc_bus_out(adc_bus));

	// short conversions keep 2048-sample periods affordable
	frig_top #(.CONV11_CYC(4), .CONV14_CYC(6)) frig_top_i (
		.sys_clk_in(sys_clk), .rst_in(rst), .integrate_in(integ),
		.output_select_field_in(osel), .sample_count_code_in(sample_count_code),
		.sense_resolution_sel_in(res), .bus_resolution_sel_in(res),
		.sense_filter_en_in(filt), .bus_filter_en_in(filt),
		.current_gain_code_in(gain), .recalc_output_bit_in(recalc),
		.adc_sense_in(adc_sense), .adc_bus_in(adc_bus),
		.reg_addr_in(addr), .reg_rdata_out(rdata), .dac_out(dac),
		.integrating_out(integrating));

	// ------------------------------------------------------------
	// common tasks
	// ------------------------------------------------------------
	task automatic test_done;
		$display("errors=%0d comparisons=%0d", errors, comparisons);
		if (errors == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("BAD t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic read_pair(input logic [7:0] a, output logic [15:0] v);
		@(posedge sys_clk) addr <= a;
		@(posedge sys_clk) addr <= a + 8'h01;
		#1 v[15:8] = rdata;
		@(posedge sys_clk);
		#1 v[7:0] = rdata;
	endtask

	// one period from idle; n is the count of cycles spent converting
	task automatic run_period(input frig_osel_t s, input logic [3:0] c,
		input logic r, input logic f, input frig_gain_t g, output int n);
		int k;
		@(posedge sys_clk) begin
			osel <= s;
			sample_count_code <= c;
			res <= r;
			filt <= f;
			gain <= g;
			integ <= 1'b1;
		end
		k = 0;
		n = 0;
		while (integrating !== 1'b1 && k < 50) begin
			@(posedge sys_clk);
			#1 k++;
		end
		while (integrating === 1'b1 && n < 30000) begin
			@(posedge sys_clk);
			#1 n++;
		end
		if (k == 50 || n == 30000)
			errors++;
		// the restarted period is dropped, the finished result stands
		@(posedge sys_clk) integ <= 1'b0;
		repeat (4) @(posedge sys_clk);
		#1;
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic test_gain_codes;
		int n;
		logic [15:0] v;
		for (int g = 0; g < 8; g++) begin
			sense_val = 14'h1000 >> g;
			run_period(2'h1, 4'h0, 1'b1, 1'b0, 3'(g), n);
			read_pair(8'h12, v);
			check(v, 16'h4000);
			check({6'h00, dac}, 16'h0100);
		end
		read_pair(8'h1c, v);
		check(v[15:8], 16'h0000);
		check(v[7:0], 16'h0000);
		bus_val = 14'h1000;
		run_period(2'h2, 4'h0, 1'b1, 1'b0, 3'h7, n);
		check({6'h00, dac}, 16'h0100);
	endtask

	task automatic test_overflow;
		int n;
		logic [15:0] v;
		bus_val = 14'h2000;
		sense_val = 14'h2000;
		run_period(2'h3, 4'h1, 1'b1, 1'b0, 3'h1, n);
		read_pair(8'h1c, v);
		check(v[15:8], 16'h0004);
		read_pair(8'h12, v);
		check(v, 16'hffc0);
		read_pair(8'h1d, v);
		check(v, 16'h8000);
		run_period(2'h3, 4'h0, 1'b1, 1'b0, 3'h2, n);
		read_pair(8'h1c, v);
		check(v[15:8], 16'h0005);
		read_pair(8'h1d, v);
		check(v, 16'hffc0);
		check({6'h00, dac}, 16'h03ff);
		// host lowers the gain and asks for a recalculation
		@(posedge sys_clk) gain <= 3'h0;
		@(posedge sys_clk) recalc <= 1'b1;
		@(posedge sys_clk) recalc <= 1'b0;
		repeat (3) @(posedge sys_clk);
		read_pair(8'h1d, v);
		check(v, 16'h4000);
		read_pair(8'h12, v);
		check(v, 16'h8000);
		read_pair(8'h1c, v);
		check(v[15:8], 16'h0000);
		check(v[7:0], 16'h0040);
	endtask

	task automatic test_timing;
		int t[4];
		int a;
		int b;
		sense_val = 14'h0100;
		bus_val = 14'h0100;
		for (int c = 0; c < 4; c++)
			run_period(2'h1, 4'(c), 1'b0, 1'b0, 3'h0, t[c]);
		check(16'(t[3] - t[2]), 16'(4 * (t[1] - t[0])));
		run_period(2'h1, 4'h1, 1'b0, 1'b1, 3'h0, a);
		check(16'(a - t[1]), 16'h0004);
		run_period(2'h1, 4'h1, 1'b1, 1'b0, 3'h0, a);
		check(16'(a - t[1]), 16'h0004);
		// a power sample is a bus then a sense conversion, twice a sense sample
		run_period(2'h3, 4'h0, 1'b0, 1'b0, 3'h0, a);
		run_period(2'h3, 4'h1, 1'b0, 1'b0, 3'h0, b);
		check(16'(b - a), 16'(2 * (t[1] - t[0])));
		run_period(2'h1, 4'hb, 1'b0, 1'b0, 3'h0, a);
		run_period(2'h1, 4'hc, 1'b0, 1'b0, 3'h0, b);
		check(16'(b), 16'(a));
		check(16'(a - t[0]), 16'(2047 * (t[1] - t[0])));
	endtask

	task automatic test_discard;
		int n;
		logic [15:0] v;
		sense_val = 14'h0800;
		run_period(2'h1, 4'h0, 1'b1, 1'b0, 3'h0, n);
		sense_val = 14'h1000;
		@(posedge sys_clk) sample_count_code <= 4'h4;
		@(posedge sys_clk) integ <= 1'b1;
		repeat (20) @(posedge sys_clk);
		integ <= 1'b0;
		repeat (3) @(posedge sys_clk);
		#1 check({15'h0000, integrating}, 16'h0000);
		repeat (60) @(posedge sys_clk);
		#1 check({6'h00, dac}, 16'h0080);
		read_pair(8'h12, v);
		check(v, 16'h2000);
		run_period(2'h1, 4'h0, 1'b1, 1'b0, 3'h0, n);
		read_pair(8'h12, v);
		check(v, 16'h4000);
		read_pair(8'h14, v);
		check(v, 16'h0000);
	endtask

	task automatic test_restart;
		int k;
		@(posedge sys_clk) sample_count_code <= 4'h0;
		@(posedge sys_clk) integ <= 1'b1;
		k = 0;
		while (integrating !== 1'b1 && k < 50) begin
			@(posedge sys_clk);
			#1 k++;
		end
		while (integrating === 1'b1 && k < 100) begin
			@(posedge sys_clk);
			#1 k++;
		end
		k = 0;
		while (integrating !== 1'b1 && k < 4) begin
			@(posedge sys_clk);
			#1 k++;
		end
		check({15'h0000, integrating}, 16'h0001);
		@(posedge sys_clk) integ <= 1'b0;
		repeat (4) @(posedge sys_clk);
		// pin-controlled select leaves the block idle
		@(posedge sys_clk) begin
			osel <= 2'h0;
			integ <= 1'b1;
		end
		repeat (3) @(posedge sys_clk);
		#1 check({15'h0000, integrating}, 16'h0000);
		@(posedge sys_clk) integ <= 1'b0;
		repeat (2) @(posedge sys_clk);
	endtask

	// ------------------------------------------------------------
	// main sequence and watchdog
	// ------------------------------------------------------------
	initial begin
		logic [15:0] v;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		read_pair(8'h1c, v);
		check(v[15:8], 16'h0000);
		check({6'h00, dac}, 16'h0000);
		test_gain_codes();
		test_overflow();
		test_timing();
		test_discard();
		test_restart();
		test_done();
	end

	// longest path is two 2048-sample periods, far below this bound
	initial begin
		repeat (60000) @(posedge sys_clk);
		errors++;
		test_done();
	end
endmodule // frig_top_tb
